// ### verilog/adccal_pkg.sv
/*
  Package for the converter calibration control block: register address, field positions,
  reset values, channel codes, averaging counts and timing constants.
  Assumes an 8-bit special function register bus on the core clock.
*/
package adccal_pkg;

  localparam logic [7:0] ADCCAL_CAL_CTRL_ADDR = 8'hF5;
  localparam logic [7:0] ADCCAL_CAL_CTRL_RESET = 8'h00;

  localparam int ADCCAL_BIT_BUSY = 7;
  localparam int ADCCAL_BIT_GAIN_DIS = 6;
  localparam int ADCCAL_BIT_AVG_HI = 5;
  localparam int ADCCAL_BIT_AVG_LO = 4;
  localparam int ADCCAL_BIT_RSVD3 = 3;
  localparam int ADCCAL_BIT_CAL_EN = 2;
  localparam int ADCCAL_BIT_TYPE = 1;
  localparam int ADCCAL_BIT_START = 0;

  localparam logic [1:0] ADCCAL_AVG_15 = 2'h0;
  localparam logic [1:0] ADCCAL_AVG_1 = 2'h1;
  localparam logic [1:0] ADCCAL_AVG_31 = 2'h2;
  localparam logic [1:0] ADCCAL_AVG_63 = 2'h3;
  localparam logic [5:0] ADCCAL_CNT_15 = 6'h0F;
  localparam logic [5:0] ADCCAL_CNT_1 = 6'h01;
  localparam logic [5:0] ADCCAL_CNT_31 = 6'h1F;
  localparam logic [5:0] ADCCAL_CNT_63 = 6'h3F;

  localparam logic [3:0] ADCCAL_CH_TEMP = 4'h8;
  localparam logic [3:0] ADCCAL_CH_DAC0 = 4'h9;
  localparam logic [3:0] ADCCAL_CH_DAC1 = 4'hA;
  localparam logic [3:0] ADCCAL_CH_AGND = 4'hB;
  localparam logic [3:0] ADCCAL_CH_VREF = 4'hC;
  localparam logic [3:0] ADCCAL_CH_DMA_STOP = 4'hF;

  // Analog mux select encodings
  localparam logic [2:0] ADCCAL_MUX_EXT = 3'h0;
  localparam logic [2:0] ADCCAL_MUX_TEMP = 3'h1;
  localparam logic [2:0] ADCCAL_MUX_DAC0 = 3'h2;
  localparam logic [2:0] ADCCAL_MUX_DAC1 = 3'h3;
  localparam logic [2:0] ADCCAL_MUX_AGND = 3'h4;
  localparam logic [2:0] ADCCAL_MUX_VREF = 3'h5;
  localparam logic [2:0] ADCCAL_MUX_NONE = 3'h6;

  localparam int ADCCAL_CLK_MHZ = 100;
  localparam int ADCCAL_TEMP_ACQ_US = 1;
  localparam int ADCCAL_TEMP_ACQ_CYC = ADCCAL_TEMP_ACQ_US * ADCCAL_CLK_MHZ;

  typedef struct packed {
    logic gain_cal_disable;
    logic [1:0] average_count;
    logic cal_type_select;
  } adccal_cfg_t;

  typedef struct packed {
    logic done;
    logic [11:0] data;
  } adccal_result_t;

endpackage

// ### verilog/adccal_chan_dec.sv
/*
  Channel code decoder: maps a 4-bit channel code to an analog mux select.
  Assumes the code and buffer-enable come from logic on the same clock.
*/
`timescale 1ns/1ps
module adccal_chan_dec
  import adccal_pkg::*;
(
  input wire logic [3:0] chan_code,
  input wire logic dac_buf_on,
  output logic [2:0] mux_sel,
  output logic is_dma_stop,
  output logic chan_illegal
);

  always_comb begin
    mux_sel = ADCCAL_MUX_NONE;
    chan_illegal = 1'b0;
    is_dma_stop = 1'b0;
    case (chan_code)
      ADCCAL_CH_TEMP: mux_sel = ADCCAL_MUX_TEMP;
      ADCCAL_CH_DAC0: begin
        mux_sel = dac_buf_on ? ADCCAL_MUX_DAC0 : ADCCAL_MUX_NONE;
        chan_illegal = !dac_buf_on;
      end
      ADCCAL_CH_DAC1: begin
        mux_sel = dac_buf_on ? ADCCAL_MUX_DAC1 : ADCCAL_MUX_NONE;
        chan_illegal = !dac_buf_on;
      end
      ADCCAL_CH_AGND: mux_sel = ADCCAL_MUX_AGND;
      ADCCAL_CH_VREF: mux_sel = ADCCAL_MUX_VREF;
      ADCCAL_CH_DMA_STOP: is_dma_stop = 1'b1;
      default: begin
        if (chan_code[3]) begin
          chan_illegal = 1'b1;
        end else begin
          mux_sel = ADCCAL_MUX_EXT;
        end
      end
    endcase
  end

endmodule

// ### verilog/adccal_ctrl.sv
/*
  Converter calibration sequencer with busy status and the calibration control register.
  Assumes an 8-bit SFR bus on sys_clk, a converter that pulses done per reading,
  and a DMA engine that fetches channel identifiers from external data memory.
*/
`timescale 1ns/1ps
module adccal_ctrl
  import adccal_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  input wire logic conv_req,
  input wire logic [3:0] chan_code,
  input wire logic dac_buf_on,
  input wire logic dma_active,
  input wire logic dma_id_valid,
  input wire logic [3:0] dma_id,
  input wire adccal_result_t adc_result,
  output logic adc_sample,
  output logic [2:0] adc_mux_sel,
  output logic cal_gain_mode,
  output logic cal_write,
  output logic [11:0] cal_value,
  output logic dma_stop,
  output logic chan_error,
  output logic busy
);

  typedef enum {ADCCAL_IDLE, ADCCAL_ACQ, ADCCAL_SAMPLE, ADCCAL_WAIT, ADCCAL_DONE} adccal_state_t;

  adccal_state_t state_reg;
  adccal_cfg_t cfg_reg;
  logic rsvd3_reg;
  logic cal_en_reg;
  logic start_reg;
  logic busy_reg;
  logic is_cal_reg;
  logic [5:0] reads_left_reg;
  logic [17:0] acc_reg;
  logic [7:0] acq_cnt_reg;
  logic [2:0] mux_reg;
  logic [7:0] rdata_reg;
  logic hit_reg;
  logic sample_reg;
  logic cal_write_reg;
  logic [11:0] cal_value_reg;
  logic dma_stop_reg;
  logic chan_err_reg;
  logic [3:0] active_code;
  logic [2:0] dec_sel;
  logic dec_stop;
  logic dec_illegal;
  logic wr_hit;
  logic cal_launch;
  logic conv_launch;
  logic [5:0] avg_total;

  function automatic logic [5:0] avg_count(input logic [1:0] sel);
    case (sel)
      ADCCAL_AVG_15: avg_count = ADCCAL_CNT_15;
      ADCCAL_AVG_1: avg_count = ADCCAL_CNT_1;
      ADCCAL_AVG_31: avg_count = ADCCAL_CNT_31;
      ADCCAL_AVG_63: avg_count = ADCCAL_CNT_63;
      default: avg_count = ADCCAL_CNT_1;
    endcase
  endfunction

  assign active_code = dma_active ? dma_id : chan_code;
  assign wr_hit = sfr_wr && (sfr_addr == ADCCAL_CAL_CTRL_ADDR);
  // Start ignored while a cycle is already running
  assign cal_launch = wr_hit && sfr_wdata[ADCCAL_BIT_START] && !busy_reg;
  assign conv_launch = conv_req && !busy_reg && !cal_launch && !dec_stop && !dec_illegal;
  assign avg_total = avg_count(cfg_reg.average_count);

  adccal_chan_dec u_dec (
    .chan_code(active_code),
    .dac_buf_on(dac_buf_on),
    .mux_sel(dec_sel),
    .is_dma_stop(dec_stop),
    .chan_illegal(dec_illegal)
  );

  // Configuration fields
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cfg_reg <= '0;
      rsvd3_reg <= 1'b0;
      cal_en_reg <= 1'b0;
    end else if (clk_en && wr_hit) begin
      cfg_reg.gain_cal_disable <= sfr_wdata[ADCCAL_BIT_GAIN_DIS];
      cfg_reg.average_count <= sfr_wdata[ADCCAL_BIT_AVG_HI:ADCCAL_BIT_AVG_LO];
      cfg_reg.cal_type_select <= sfr_wdata[ADCCAL_BIT_TYPE];
      rsvd3_reg <= sfr_wdata[ADCCAL_BIT_RSVD3];
      cal_en_reg <= sfr_wdata[ADCCAL_BIT_CAL_EN];
    end
  end

  // Sequencer
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_reg <= ADCCAL_IDLE;
      start_reg <= 1'b0;
      busy_reg <= 1'b0;
      is_cal_reg <= 1'b0;
      reads_left_reg <= '0;
      acc_reg <= '0;
      acq_cnt_reg <= '0;
      mux_reg <= ADCCAL_MUX_NONE;
      sample_reg <= 1'b0;
      cal_write_reg <= 1'b0;
      cal_value_reg <= '0;
    end else if (clk_en) begin
      sample_reg <= 1'b0;
      cal_write_reg <= 1'b0;
      case (state_reg)
        ADCCAL_IDLE: begin
          if (cal_launch) begin
            start_reg <= 1'b1;
            busy_reg <= 1'b1;
            is_cal_reg <= 1'b1;
            reads_left_reg <= avg_count(sfr_wdata[ADCCAL_BIT_AVG_HI:ADCCAL_BIT_AVG_LO]);
            acc_reg <= '0;
            // Full scale uses reference, zero scale uses ground
            mux_reg <= sfr_wdata[ADCCAL_BIT_TYPE] ? ADCCAL_MUX_VREF : ADCCAL_MUX_AGND;
            state_reg <= ADCCAL_SAMPLE;
          end else if (conv_launch) begin
            busy_reg <= 1'b1;
            is_cal_reg <= 1'b0;
            reads_left_reg <= ADCCAL_CNT_1;
            mux_reg <= dec_sel;
            acq_cnt_reg <= '0;
            state_reg <= (dec_sel == ADCCAL_MUX_TEMP) ? ADCCAL_ACQ : ADCCAL_SAMPLE;
          end
        end
        ADCCAL_ACQ: begin
          if (acq_cnt_reg == 8'(ADCCAL_TEMP_ACQ_CYC - 1)) begin
            state_reg <= ADCCAL_SAMPLE;
          end else begin
            acq_cnt_reg <= acq_cnt_reg + 8'h01;
          end
        end
        ADCCAL_SAMPLE: begin
          sample_reg <= 1'b1;
          state_reg <= ADCCAL_WAIT;
        end
        ADCCAL_WAIT: begin
          if (adc_result.done) begin
            acc_reg <= acc_reg + 18'(adc_result.data);
            reads_left_reg <= reads_left_reg - 6'h01;
            state_reg <= (reads_left_reg == ADCCAL_CNT_1) ? ADCCAL_DONE : ADCCAL_SAMPLE;
          end
        end
        ADCCAL_DONE: begin
          if (is_cal_reg) begin
            cal_value_reg <= 12'(acc_reg / 18'(avg_total));
            // Gain result discarded when gain calibration disabled
            cal_write_reg <= !(cfg_reg.cal_type_select && cfg_reg.gain_cal_disable);
          end
          start_reg <= 1'b0;
          busy_reg <= 1'b0;
          mux_reg <= ADCCAL_MUX_NONE;
          state_reg <= ADCCAL_IDLE;
        end
        default: state_reg <= ADCCAL_IDLE;
      endcase
    end
  end

  // DMA stop marker and channel error flags
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dma_stop_reg <= 1'b0;
      chan_err_reg <= 1'b0;
    end else if (clk_en) begin
      dma_stop_reg <= dma_active && dma_id_valid && dec_stop;
      chan_err_reg <= conv_req && !busy_reg && dec_illegal;
    end
  end

  // Register read port; busy is read-only
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= ADCCAL_CAL_CTRL_RESET;
      hit_reg <= 1'b0;
    end else if (clk_en) begin
      hit_reg <= (sfr_rd || sfr_wr) && (sfr_addr == ADCCAL_CAL_CTRL_ADDR);
      if (sfr_rd && (sfr_addr == ADCCAL_CAL_CTRL_ADDR)) begin
        rdata_reg <= {busy_reg, cfg_reg.gain_cal_disable, cfg_reg.average_count,
                      rsvd3_reg, cal_en_reg, cfg_reg.cal_type_select, start_reg};
      end else begin
        rdata_reg <= ADCCAL_CAL_CTRL_RESET;
      end
    end
  end

  assign sfr_rdata = rdata_reg;
  assign sfr_hit = hit_reg;
  assign adc_sample = sample_reg;
  assign adc_mux_sel = mux_reg;
  assign cal_gain_mode = cfg_reg.cal_type_select;
  assign cal_write = cal_write_reg;
  assign cal_value = cal_value_reg;
  assign dma_stop = dma_stop_reg;
  assign chan_error = chan_err_reg;
  assign busy = busy_reg;

endmodule

// ### bench/adccal_ctrl_sva.sv
/* Port assertions for the calibration control block.
   Bound onto adccal_ctrl from the testbench top. */
`timescale 1ns/1ps
module adccal_ctrl_sva
  import adccal_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire logic conv_req,
  input wire logic dma_active,
  input wire logic dma_id_valid,
  input wire logic [3:0] dma_id,
  input wire logic adc_sample,
  input wire logic cal_write,
  input wire logic dma_stop,
  input wire logic busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic acc;
  logic stp;
  assign acc = clk_en && (sfr_wr || sfr_rd) && sfr_addr == ADCCAL_CAL_CTRL_ADDR;
  assign stp = clk_en && dma_active && dma_id_valid && dma_id == 4'hF;
  property p_hit; acc |=> sfr_hit; endproperty
  a_hit: assert property (p_hit) else $error("no hit");
  property p_miss; !acc |=> !sfr_hit; endproperty
  a_miss: assert property (p_miss) else $error("stray hit");
  property p_rdz; !(acc && sfr_rd) |=> sfr_rdata == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("stray rdata");
  property p_start; acc && sfr_wr && sfr_wdata[0] && !busy |=> busy; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_b7; acc && sfr_wr && !sfr_wdata[0] && !busy && !conv_req |=> !busy; endproperty
  a_b7: assert property (p_b7) else $error("busy written");
  property p_stop; stp |=> dma_stop; endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_nostop; !stp |=> !dma_stop; endproperty
  a_nostop: assert property (p_nostop) else $error("stray stop");
  property p_wrdone; cal_write |-> !busy ##1 !cal_write; endproperty
  a_wrdone: assert property (p_wrdone) else $error("busy at end");
  property p_smp; adc_sample |-> busy; endproperty
  a_smp: assert property (p_smp) else $error("sample idle");
  cover property (cal_write);
  cover property (dma_stop);
  cover property (busy ##1 !busy);
endmodule

// ### bench/test_adccal_ctrl.sv
/* Self-checking bench for adccal_ctrl.
   Bench plays core bus, converter and DMA engine. */
`timescale 1ns/1ps
module test_adccal_ctrl;
  import adccal_pkg::*;
  logic sys_clk, reset, clk_en, sfr_wr, sfr_rd, sfr_hit, conv_req, dac_buf_on;
  logic dma_active, dma_id_valid, adc_sample, cal_gain_mode, cal_write;
  logic dma_stop, chan_error, busy;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd_val;
  logic [3:0] chan_code, dma_id;
  logic [2:0] adc_mux_sel;
  logic [11:0] cal_value, smp, got;
  logic [1:0] av;
  logic t;
  adccal_result_t adc_result = '0;
  logic [31:0] seed = 32'h0000005B;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, n_smp, n_wr;
  localparam logic [7:0] A = ADCCAL_CAL_CTRL_ADDR;
  adccal_ctrl dut (.*);
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function int n_avg(logic [1:0] a);
    return a == 0 ? 15 : a == 1 ? 1 : a == 2 ? 31 : 63;
  endfunction
  task chk(input logic [11:0] g, input logic [11:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task end_sim();
    $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1;
    @(posedge sys_clk);
    #1 sfr_wr = 0;
    chk(sfr_hit, a == A);
  endtask
  task rd();
    sfr_addr = A;
    sfr_rd = 1;
    @(posedge sys_clk);
    #1 sfr_rd = 0;
    rd_val = sfr_rdata;
  endtask
  task wait_idle();
    int k;
    k = 0;
    while (busy !== 0 && k < 3000) begin
      @(posedge sys_clk);
      #1 k++;
    end
    // One more edge so the end-of-cycle write pulse is counted
    @(posedge sys_clk);
    #1 chk(k < 3000, 1);
  endtask
  task conv(input logic [3:0] c, input logic b, input logic [2:0] m, input logic e);
    chan_code = c;
    dac_buf_on = b;
    conv_req = 1;
    @(posedge sys_clk);
    #1 conv_req = 0;
    chk(chan_error, e);
    chk(busy, !e);
    if (!e) chk(adc_mux_sel, m);
    wait_idle();
  endtask
  // Converter model: done two cycles after each sample pulse
  always @(posedge sys_clk) begin
    if (adc_sample) begin
      n_smp++;
      repeat (2) @(posedge sys_clk);
      #1 adc_result = {1'b1, smp};
      @(posedge sys_clk);
      #1 adc_result = '0;
    end
  end
  always @(posedge sys_clk) begin
    if (cal_write) begin
      got = cal_value;
      n_wr++;
    end
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    reset = 1;
    clk_en = 1;
    {sfr_wr, sfr_rd, conv_req, dac_buf_on, dma_active, dma_id_valid} = '0;
    sfr_addr = '0;
    sfr_wdata = '0;
    chan_code = '0;
    dma_id = '0;
    repeat (6) @(posedge sys_clk);
    #1 reset = 0;
    rd();
    chk(rd_val, 8'h00);
    wr(8'hF4, 8'(rnd()));
    chk(busy, 0);
    for (int i = 0; i < 4; i++) begin
      smp = 12'(rnd());
      av = 2'(i);
      t = av[0];
      n_smp = 0;
      n_wr = 0;
      wr(A, {2'b00, av, 2'b01, t, 1'b1});
      chk(cal_gain_mode, t);
      chk(adc_mux_sel, t ? 3'h5 : 3'h4);
      rd();
      chk(rd_val, {2'b10, av, 2'b01, t, 1'b1});
      wait_idle();
      chk(12'(n_smp), 12'(n_avg(av)));
      chk(12'(n_wr), 1);
      chk(got, smp);
      rd();
      chk(rd_val, {2'b00, av, 2'b01, t, 1'b0});
    end
    n_wr = 0;
    wr(A, 8'hD7);
    wait_idle();
    chk(12'(n_wr), 0);
    rd();
    chk(rd_val, 8'h56);
    wr(A, 8'h84);
    chk(busy, 0);
    rd();
    chk(rd_val, 8'h04);
    conv(4'h8, 0, 3'h1, 0);
    conv(4'hB, 0, 3'h4, 0);
    conv(4'hC, 0, 3'h5, 0);
    conv(4'h9, 0, 3'h0, 1);
    conv(4'hA, 1, 3'h3, 0);
    conv(4'hD, 1, 3'h0, 1);
    for (int j = 0; j < 2; j++) begin
      dma_active = j[0];
      dma_id = 4'hF;
      dma_id_valid = 1;
      @(posedge sys_clk);
      #1 dma_id_valid = 0;
      chk(dma_stop, j[0]);
    end
    dma_active = 0;
    end_sim();
  end
endmodule
bind adccal_ctrl adccal_ctrl_sva chk_i (.*);
